// *** dv/sadc_cmp_model.sv ***
/*
  Comparator model facing the converter control block.
  Assumes dac_trial and mux_chan settle within each core_clk cycle.
*/
`timescale 1ns/1ps

module sadc_cmp_model (
  input wire logic core_clk,
  input wire logic powered,
  input wire logic [1:0] mux_chan,
  input wire logic [7:0] dac_trial,
  input wire logic [3:0][7:0] ain,
  output logic cmp_result
);
  logic cmp_q = 1'b0;

  // Powered down gives no valid decision, so the output wanders
  always @(posedge core_clk) begin
    if (powered) begin
      cmp_q <= (ain[mux_chan] >= dac_trial);
    end else begin
      cmp_q <= ~cmp_q;
    end
  end
  assign cmp_result = cmp_q;
endmodule

// *** dv/sadc_ctrl_test.sv ***
/*
  Self-checking bench for sadc_ctrl with a comparator model and a
  queue-based reference. Assumes a 20 MHz core clock, registers at 0/1.
*/
`timescale 1ns/1ps

module sadc_ctrl_test;
  import sadc_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, addr = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic sleep_req = 1'b0, int_osc_tick = 1'b0, first_comparator_output_en = 1'b0;
  logic cmp_result, sample_en, converter_powered, busy;
  logic [7:0] wdata = 8'h00, rdata, dac_trial;
  logic [2:0] dac_code_valid, analog_pin_mask, digital_out_disable;
  logic [1:0] mux_chan, tick_cnt = 2'h0;
  logic [3:0][7:0] ain = '0;
  logic [2:0] pm [4] = '{3'b000, 3'b100, 3'b101, 3'b111};
  int dv [4] = '{32, 16, 8, 32};
  int mismatches = 0, checks_done = 0;
  logic [7:0] exp_q [$];

  always #25 core_clk = ~core_clk;
  // Internal oscillator: one tick every four core clocks
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    int_osc_tick <= (tick_cnt == 2'h3);
  end

  sadc_ctrl sadc_ctrl_inst (.core_clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .sleep_req, .int_osc_tick, .cmp_result, .first_comparator_output_en, .dac_code_valid,
    .dac_trial, .sample_en, .mux_chan, .converter_powered, .analog_pin_mask,
    .digital_out_disable, .busy);
  sadc_cmp_model sadc_cmp_model_inst (.core_clk, .powered(converter_powered), .mux_chan,
    .dac_trial, .ain, .cmp_result);

  // ----------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n, pos;
    logic [1:0] d;
    logic [7:0] r, prev;
    void'($urandom(32'h78B2));
    ain <= $urandom;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(1'b0, r); chk(r, 8'hFC, "ctrl reset");
    rd(1'b1, prev); chk(prev, 8'h00, "result reset");
    wr(1'b0, 8'hF2);
    rd(1'b0, r); chk(r, 8'hF0, "go while disabled");
    for (int p = 0; p < 8; p++) begin
      first_comparator_output_en <= p[2];
      wr(1'b0, {p[1:0], 6'h3C});
      #1 chk(8'(analog_pin_mask), 8'(pm[p[1:0]] & {~p[2], 2'b11}), "pins");
      if (!p[2]) chk(8'(digital_out_disable), 8'(pm[p[1:0]]), "digital off");
    end
    first_comparator_output_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = 2'(i);
      exp_q.push_back(ain[d]);
      wr(1'b0, {2'b11, d, d, 2'b11});
      #1 chk(8'(busy), 8'h01, "go sets busy");
      chk(8'(converter_powered), 8'h01, "powered");
      rd(1'b1, r); chk(r, prev, "old result while sampling");
      chk(8'(sample_en), 8'h01, "sampling phase");
      chk(8'(mux_chan), 8'(d), "channel latched");
      wr(1'b0, {2'b11, d ^ 2'b01, d ^ 2'b01, 2'b11});
      n = 4;
      while (busy === 1'b1 && n < 5000) begin
        @(posedge core_clk);
        n++;
      end
      chk(8'(n > 13 * dv[i] - 6 && n < 13 * dv[i] + 6), 8'h01, "duration");
      chk(8'(mux_chan), 8'(d), "channel held");
      chk(8'(sample_en), 8'h00, "sampling over");
      prev = exp_q.pop_front();
      rd(1'b1, r); chk(r, prev, "result");
    end
    wr(1'b1, 8'h55);
    rd(1'b1, r); chk(r, prev, "result read only");
    wr(1'b0, 8'hE3);
    repeat (48 + $urandom % 40) @(posedge core_clk);
    wr(1'b0, 8'hE1);
    #1 chk(8'(busy), 8'h00, "abort stops");
    rd(1'b1, r);
    pos = 0;
    for (int j = 7; j >= 0; j--) if (r[j]) pos = j;
    chk(r, ((ain[0] >> (pos + 1)) << (pos + 1)) | (8'h01 << pos), "partial");
    wr(1'b0, 8'hA3);
    repeat (10) @(posedge core_clk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(8'({busy, converter_powered}), 8'h00, "sleep aborts");
    rd(1'b0, r); chk(r, 8'hBC, "sleep ctrl");
    sleep_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(1'b0, r); chk(r, 8'hFC, "wake ctrl");
    summarize();
  end
endmodule

// *** hw/sadc_consts.svh ***
/*
  Constants for the successive-approximation converter control block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 20 MHz core clock that also serves as the instruction clock.
*/
// What this block does
// - Convert selected input to 8-bit unsigned result, supply is the only reference.
// - Divider field picks bit period: /32, /16, /8, internal oscillator /8.
// - Every conversion takes exactly 13 bit periods whatever the divisor.
// - Divider change mid-conversion applies only from the next start.
// - Bit period comes from the instruction clock, or from the internal oscillator in setting 11; nothing converts in sleep.
// - Pin field: 00 none, 01 input two, 10 two+zero, 11 all three.
// - Pin field resets to 11 and acts regardless of enable bit.
// - Digital output is disabled on every pin configured analog.
// - Enabled first comparator output overrides analog input two.
// - Channel field: 00 zero, 01 one, 10 two, 11 internal 0.6V reference.
// - Channel change mid-conversion applies only after completion.
// - Writing start flag begins conversion; hardware clears it on completion.
// - Software clearing start flag aborts at once, keeping resolved bits.
// - Start flag cannot be set while the enable bit is zero.
// - Sleep clears start and enable, sets divider and channel to 11.
// - Reset or wake leaves fields at 11, start and enable at zero.
// - Result holds old value through sampling, cleared when sampling ends.
// - Marker one shifts in from top; nine shifts end the conversion.
// - After abort the marker position shows how many bits were resolved.
// - Enable one powers the converter; zero powers it down.
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

`define SADC_ADDR_CTRL 1'h0
`define SADC_ADDR_RES 1'h1

`define SADC_BIT_EN 0
`define SADC_BIT_GO 1
`define SADC_CTRL_RESET 8'hFC
`define SADC_SLEEP_MASK 8'hFC
`define SADC_SLEEP_SET 8'h3C

`define SADC_DIV_32 8'h20
`define SADC_DIV_16 8'h10
`define SADC_DIV_8 8'h08
`define SADC_PERIODS 4'hD
`define SADC_SAMPLE_PERIODS 4'h4

`endif

// *** hw/sadc_ctrl.sv ***
/*
  Conversion control for an 8-bit successive-approximation converter.
  Assumes the comparator and sampling network sit outside; cmp_result
  is synchronous to core_clk, and sleep_req is a level from the core.
*/
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sadc_consts.svh"

module sadc_ctrl
  import sadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic sleep_req,
  input wire logic int_osc_tick,
  input wire logic cmp_result,
  input wire logic first_comparator_output_en,
  output logic [2:0] dac_code_valid,
  output logic [7:0] dac_trial,
  output logic sample_en,
  output logic [1:0] mux_chan,
  output logic converter_powered,
  output logic [2:0] analog_pin_mask,
  output logic [2:0] digital_out_disable,
  output logic busy
);

  // ------------------------------------------------------------
  // Control register and bus
  // ------------------------------------------------------------
  sadc_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] result_q, result_d;
  logic [7:0] rdata_q, rdata_d;
  sadc_state_t state_q, state_d;
  logic [1:0] div_lat_q, div_lat_d;
  logic [1:0] chan_lat_q, chan_lat_d;
  logic [7:0] pre_q, pre_d;
  logic [3:0] per_q, per_d;
  logic sleep_q;
  logic tick;
  logic done;
  logic [2:0] bit_idx;
  logic wr_ctrl;
  sadc_ctrl_t wr_val;

  assign wr_ctrl = wr_stb && (addr == `SADC_ADDR_CTRL);
  assign wr_val = sadc_ctrl_t'(wdata);

  always_comb begin
    ctrl_d = ctrl_q;
    if (sleep_req) begin
      // Entering sleep aborts and resets divider and channel
      ctrl_d = sadc_ctrl_t'((ctrl_q & `SADC_SLEEP_MASK) | `SADC_SLEEP_SET);
      ctrl_d.pins = ctrl_q.pins;
      ctrl_d.go = 1'b0;
      ctrl_d.en = 1'b0;
    end else if (!sleep_req && sleep_q) begin
      ctrl_d = sadc_ctrl_t'(`SADC_CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_d = wr_val;
        // Go only sticks when enabled by the same write
        ctrl_d.go = wr_val.go && wr_val.en;
      end
      // Completion outranks a same-cycle write of go
      if (done) begin
        ctrl_d.go = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= sadc_ctrl_t'(`SADC_CTRL_RESET);
      sleep_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      sleep_q <= sleep_req;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (rd_stb) begin
      rdata_d = (addr == `SADC_ADDR_CTRL) ? 8'(ctrl_q) : result_q;
    end
  end
  assign rdata = rdata_q;

  // ------------------------------------------------------------
  // Bit period generation
  // ------------------------------------------------------------
  logic [7:0] pre_top;
  always_comb begin
    unique case (div_lat_q)
      2'b00: pre_top = `SADC_DIV_32 - 8'h01;
      2'b01: pre_top = `SADC_DIV_16 - 8'h01;
      default: pre_top = `SADC_DIV_8 - 8'h01;
    endcase
  end

  // Internal oscillator setting counts its own ticks, the rest count core clocks
  logic pre_step;
  assign pre_step = (div_lat_q == 2'b11) ? int_osc_tick : 1'b1;
  assign tick = (state_q != SADC_IDLE) && pre_step && (pre_q == pre_top);

  // ------------------------------------------------------------
  // Conversion sequence
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    div_lat_d = div_lat_q;
    chan_lat_d = chan_lat_q;
    pre_d = pre_q;
    per_d = per_q;
    result_d = result_q;
    done = 1'b0;
    unique case (state_q)
      SADC_IDLE: begin
        if (ctrl_q.go && ctrl_q.en && !sleep_req) begin
          state_d = SADC_SAMPLE;
          div_lat_d = ctrl_q.div;
          chan_lat_d = ctrl_q.chan;
          pre_d = 8'h00;
          per_d = 4'h0;
        end
      end
      SADC_SAMPLE, SADC_CONVERT: begin
        if (pre_step) begin
          pre_d = tick ? 8'h00 : pre_q + 8'h01;
        end
        if (!ctrl_q.go || !ctrl_q.en || sleep_req) begin
          // Abort freezes the result with the decisions made so far
          state_d = SADC_IDLE;
        end else if (tick) begin
          per_d = per_q + 4'h1;
          if (state_q == SADC_SAMPLE && per_q == `SADC_SAMPLE_PERIODS - 4'h1) begin
            // Old result stays readable until sampling closes
            result_d = 8'h00;
            state_d = SADC_CONVERT;
          end else if (state_q == SADC_CONVERT && per_q == `SADC_SAMPLE_PERIODS) begin
            // First shift brings the marker in at the top
            result_d = 8'h80;
          end else if (state_q == SADC_CONVERT) begin
            // Decision replaces the marker, marker moves one bit down
            result_d[bit_idx] = cmp_result;
            if (bit_idx != 3'h0) begin
              result_d[bit_idx - 3'h1] = 1'b1;
            end
          end
          if (per_q == `SADC_PERIODS - 4'h1) begin
            state_d = SADC_IDLE;
            done = 1'b1;
          end
        end
      end
      default: state_d = SADC_IDLE;
    endcase
  end

  // Decisions also land in the shadow word, which with the trial bit drives dac_trial.
  logic [7:0] code_q, code_d;
  assign bit_idx = 3'(4'(`SADC_PERIODS) - 4'h1 - per_q);
  always_comb begin
    code_d = code_q;
    if (state_q == SADC_SAMPLE) begin
      code_d = 8'h00;
    end else if (state_q == SADC_CONVERT && tick && per_q > `SADC_SAMPLE_PERIODS) begin
      code_d[bit_idx] = cmp_result;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SADC_IDLE;
      div_lat_q <= 2'b11;
      chan_lat_q <= 2'b11;
      pre_q <= 8'h00;
      per_q <= 4'h0;
      result_q <= 8'h00;
      code_q <= 8'h00;
    end else begin
      state_q <= state_d;
      div_lat_q <= div_lat_d;
      chan_lat_q <= chan_lat_d;
      pre_q <= pre_d;
      per_q <= per_d;
      result_q <= result_d;
      code_q <= code_d;
    end
  end

  // ------------------------------------------------------------
  // Pin configuration and analog front-end controls
  // ------------------------------------------------------------
  always_comb begin
    unique case (ctrl_q.pins)
      2'b00: analog_pin_mask = 3'b000;
      2'b01: analog_pin_mask = 3'b100;
      2'b10: analog_pin_mask = 3'b101;
      default: analog_pin_mask = 3'b111;
    endcase
    if (first_comparator_output_en) begin
      analog_pin_mask[2] = 1'b0;
    end
  end
  // Independent of the enable bit
  assign digital_out_disable = analog_pin_mask;

  assign converter_powered = ctrl_q.en;
  assign sample_en = (state_q == SADC_SAMPLE);
  assign mux_chan = chan_lat_q;
  assign dac_trial = code_q | ((state_q == SADC_CONVERT) ? (8'h01 << bit_idx) : 8'h00);
  assign dac_code_valid = bit_idx;
  assign busy = ctrl_q.go;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Cycles spent away from idle, so a whole run can be timed
  logic [11:0] run_cnt_q, run_cnt_d;
  logic [11:0] run_len;
  assign run_len = 12'(`SADC_PERIODS) * (12'(pre_top) + 12'h001) - 12'h001;

  always_comb begin
    run_cnt_d = (state_q == SADC_IDLE) ? 12'h000 : run_cnt_q + 12'h001;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cnt_q <= 12'h000;
    end else begin
      run_cnt_q <= run_cnt_d;
    end
  end

  // Control register and register reads
  AST_GO_NEEDS_EN: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ctrl_q.go |-> ctrl_q.en)
    else $error("go set while disabled");
  AST_EN_WRITE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    wr_ctrl && !wdata[`SADC_BIT_EN] |=> !busy)
    else $error("go kept after enable cleared");
  AST_SLEEP_DEFAULTS: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    sleep_req && !$past(sleep_req) |=> !ctrl_q.go && !ctrl_q.en && ctrl_q.div == 2'b11
      && ctrl_q.chan == 2'b11 && ctrl_q.pins == $past(ctrl_q.pins))
    else $error("sleep defaults wrong");
  AST_WAKE_DEFAULTS: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !sleep_req && $past(sleep_req) |=> 8'(ctrl_q) == `SADC_CTRL_RESET)
    else $error("wake defaults wrong");
  AST_RD_CTRL: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    rd_stb && addr == `SADC_ADDR_CTRL |=> rdata == 8'($past(ctrl_q)))
    else $error("control read wrong");
  AST_RD_RES: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    rd_stb && addr == `SADC_ADDR_RES |=> rdata == $past(result_q))
    else $error("result read wrong");

  // Sequencing
  AST_START: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_IDLE && ctrl_q.go && !sleep_req |=> state_q == SADC_SAMPLE)
    else $error("go did not start");
  AST_ABORT_IDLE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE && !ctrl_q.go |=> state_q == SADC_IDLE)
    else $error("abort did not stop");
  AST_SLEEP_STOPS: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    sleep_req |=> state_q == SADC_IDLE && !converter_powered)
    else $error("conversion ran in sleep");
  AST_DONE_CLEARS: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    done |=> !ctrl_q.go)
    else $error("go not cleared on done");
  AST_RUN_LENGTH: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    done && div_lat_q != 2'b11 |-> run_cnt_q == run_len)
    else $error("conversion length wrong");
  AST_PER_BOUND: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE |-> per_q < `SADC_PERIODS)
    else $error("period count overrun");
  AST_PRE_BOUND: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE |-> pre_q <= pre_top)
    else $error("prescaler overrun");
  AST_OSC_STEP: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE && div_lat_q == 2'b11 && !int_osc_tick |=> $stable(pre_q))
    else $error("prescaler moved without oscillator tick");
  AST_DIV_LATCH: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_SAMPLE && $past(state_q) == SADC_IDLE |-> div_lat_q == $past(ctrl_q.div))
    else $error("divider not taken at start");
  AST_DIV_HELD: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE && $past(state_q) != SADC_IDLE |-> $stable(div_lat_q))
    else $error("divider changed mid conversion");
  AST_CHAN_LATCH: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_SAMPLE && $past(state_q) == SADC_IDLE |-> mux_chan == $past(ctrl_q.chan))
    else $error("channel not taken at start");
  AST_CHAN_HELD: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE && $past(state_q) != SADC_IDLE |-> $stable(mux_chan))
    else $error("channel changed mid conversion");

  // Sampling span and result word
  AST_SAMPLE_SPAN: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_SAMPLE |-> per_q < `SADC_SAMPLE_PERIODS)
    else $error("sampling too long");
  AST_RES_HELD: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_SAMPLE && $past(state_q) == SADC_SAMPLE |-> $stable(result_q))
    else $error("result changed in sampling");
  AST_RES_CLEARED: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_CONVERT && $past(state_q) == SADC_SAMPLE |-> result_q == 8'h00)
    else $error("result not cleared after sampling");
  AST_MARKER_IN: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_CONVERT && per_q == 4'h5 && $past(per_q) == 4'h4 |-> result_q == 8'h80)
    else $error("marker not shifted in");
  AST_MARKER_POS: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_CONVERT && per_q > `SADC_SAMPLE_PERIODS |-> result_q[bit_idx]
      && (result_q & ((8'h01 << bit_idx) - 8'h01)) == 8'h00)
    else $error("marker out of place");
  AST_TRIAL_MATCH: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_CONVERT && per_q > `SADC_SAMPLE_PERIODS |-> dac_trial == result_q)
    else $error("trial code disagrees with result");

  // Pins
  AST_PIN_OVR: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    first_comparator_output_en |-> !analog_pin_mask[2])
    else $error("comparator override lost");
  AST_PIN_TWO: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ctrl_q.pins != 2'b00 && !first_comparator_output_en |-> analog_pin_mask[2])
    else $error("input two not analog");
  AST_PINS_ALL: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ctrl_q.pins == 2'b11 && !first_comparator_output_en |-> digital_out_disable == 3'b111)
    else $error("digital output left on analog pin");

  CV_DONE: cover property (@(posedge core_clk) disable iff (sys_rst) done);
  CV_ABORT: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_q == SADC_CONVERT && !ctrl_q.go);
  CV_SLEEP: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_q != SADC_IDLE && sleep_req);
  CV_WAKE: cover property (@(posedge core_clk) disable iff (sys_rst)
    !sleep_req && sleep_q);
  CV_OSC_RUN: cover property (@(posedge core_clk) disable iff (sys_rst)
    done && div_lat_q == 2'b11);

endmodule

// *** hw/sadc_pkg.sv ***
/*
  Types for the converter control block.
  Assumes sadc_consts.svh is available on the include path.
*/
package sadc_pkg;
  typedef struct packed {
    logic [1:0] pins;
    logic [1:0] div;
    logic [1:0] chan;
    logic go;
    logic en;
  } sadc_ctrl_t;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_state_t;
endpackage
